// [verilog/cgc_counter_regs.vh]
// Register map, field positions and reset values of the counter channel.
// Assumes a 32-bit Avalon-MM slave with byte addresses; no code lives here.
`ifndef CGC_COUNTER_REGS_VH
`define CGC_COUNTER_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets
`define CGC_ADDR_W 5
`define CGC_OFS_CTRL 5'h00
`define CGC_OFS_MODE 5'h04
`define CGC_OFS_LOAD 5'h08
`define CGC_OFS_END 5'h0C
`define CGC_OFS_CMP 5'h10
`define CGC_OFS_HYST 5'h14
`define CGC_OFS_COUNT 5'h18
`define CGC_OFS_STATUS 5'h1C

////////////////////////////////////////////////////////////////////////////////
// Control word bits
`define CGC_CTRL_GATE_OPEN 0
`define CGC_CTRL_GATE_CLOSE 1
`define CGC_CTRL_STS_RESET 2
`define CGC_CTRL_CMP_EN 3

// Mode word fields
`define CGC_MODE_FUNC_LSB 0
`define CGC_MODE_FUNC_MSB 5
`define CGC_MODE_COND_LSB 8
`define CGC_MODE_COND_MSB 10
`define CGC_MODE_GATE_IRQ 16

// Counter function codes
`define CGC_FUNC_ENDLESS 6'b00_0000
`define CGC_FUNC_ONCE_FWD 6'b00_0001
`define CGC_FUNC_ONCE_BWD 6'b00_0010
`define CGC_FUNC_ONCE_NONE 6'b00_0100
`define CGC_FUNC_PER_FWD 6'b00_1000
`define CGC_FUNC_PER_BWD 6'b01_0000
`define CGC_FUNC_PER_NONE 6'b10_0000

// Comparison condition codes
`define CGC_COND_NEVER 3'b000
`define CGC_COND_GE 3'b001
`define CGC_COND_LE 3'b010
`define CGC_COND_EQ 3'b100

// Status word bits
`define CGC_STS_GATE 0
`define CGC_COMPARE_LATCHED_FLAG_LIVE 1
`define CGC_COMPARE_LATCHED_FLAG_LATCH 2
`define CGC_STS_HYST 3
`define CGC_COMPARE_LATCHED_FLAG_EN 4
`define CGC_STS_AUTO_CLOSED 5

// Reset values
`define CGC_RST_WORD 32'h0000_0000
`define CGC_RST_HYST 8'h00

`endif

// [verilog/cgc_counter_core.v]
// One signed 32-bit counter channel with software gate, compare and hysteresis.
// Assumes UP/DOWN count pulses are one-cycle strobes from decode logic on CLK.
//
// Function
// - Once forward: start at load, after end-1 next up pulse reloads and closes gate.
// - Once backward: start at load, after end+1 next down pulse reloads and closes gate.
// - After auto close, host gives rising gate edge; counting resumes from load value, except once without direction under interrupt gate, which holds the count.
// - Forward direction may go below lower limit; end value range -2^31+1..2^31-1.
// - Backward direction may go above upper limit; end value range -2^31..2^31-2.
// - Periodic without direction counts both ways over full range, wrapping.
// - Periodic: pulse after end-1 or end+1 reloads load value, gate stays open.
// - After auto close in once mode, only a new open edge reopens the gate.
// - Abort gate behaviour restarts from load value on each reopening.
// - Interrupt gate behaviour continues from held count on each reopening after a host close.
// - Live compare bit updates only while compare update enable is set.
// - GE holds bit while count >= compare, LE while <=; never leaves it alone.
// - EQ sets on reaching value, only from main direction if one is configured.
// - Live bit setting also sets latched flag, cleared by status reset bit.
// - Hysteresis width 0..255; 0 and 1 disable it; it shapes compare results.
// - Active window keeps its width; new width applies at next arming.
// - Meeting condition arms hysteresis; result cannot be set again until count leaves window.
// - GE armed: falling below compare clears bit; re-reaching does not set it.
// - EQ armed: bit stays set inside window, clears on exit either side.
// - Condition codes: never 000, GE 001, LE 010, EQ 100.
// - Gate config bit: 0 selects abort, 1 selects interrupt.
// - Six-bit function field selects endless, once or periodic modes.
`timescale 1ns/1ps
`default_nettype none
`include "cgc_counter_regs.vh"

module cgc_counter_core #(
   parameter HYST_W = 8
) (
   input wire CLK,
   input wire RST_B,
   input wire [`CGC_ADDR_W-1:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   input wire UP_PULSE,
   input wire DOWN_PULSE,
   output wire [31:0] COUNT_VALUE,
   output wire GATE_OPEN,
   output wire COMPARE_LIVE,
   output wire COMPARE_LATCHED
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Merge write data into a word under byte enables
   function [31:0] be_merge;
      input [31:0] old_w;
      input [31:0] new_w;
      input [3:0] be;
      integer i;
      begin
         be_merge = old_w;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               be_merge[i*8 +: 8] = new_w[i*8 +: 8];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   reg ack_q;
   reg [31:0] ctrl_q;
   reg [31:0] mode_q;
   reg [31:0] load_q;
   reg [31:0] end_q;
   reg [31:0] cmp_q;
   reg [HYST_W-1:0] hyst_width_q;
   reg [31:0] cnt_q;
   reg [31:0] cnt_d;
   reg gate_q;
   reg gate_d;
   reg auto_closed_q;
   reg auto_closed_d;
   reg started_q;
   reg [1:0] last_dir_q;
   reg [1:0] last_dir_d;
   reg live_q;
   reg live_d;
   reg latched_q;
   reg hyst_q;
   reg hyst_d;
   reg [31:0] hyst_center_q;
   reg [HYST_W-1:0] hyst_win_q;
   reg [31:0] rd_mux;

   wire wr_take;
   wire [31:0] ctrl_new;
   wire open_edge;
   wire close_edge;
   wire sts_reset;
   wire cmp_en;
   wire [5:0] func;
   wire [2:0] cond;
   wire gate_irq;
   wire once_mode;
   wire main_fwd;
   wire main_bwd;
   wire no_dir_once;
   wire step_up;
   wire step_dn;
   wire at_end_fwd;
   wire at_end_bwd;
   wire at_max;
   wire at_min;
   wire ge_raw;
   wire le_raw;
   wire eq_raw;
   wire eq_hit;
   wire signed [32:0] hyst_diff;
   wire signed [32:0] hyst_span;
   wire out_of_window;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then answer
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
   assign wr_take = AVS_WRITE & ack_q;

   // Acknowledge pulse and read data capture
   always @(posedge CLK) begin
      if (!RST_B) begin
         ack_q <= 1'b0;
         AVS_READDATA <= `CGC_RST_WORD;
      end else begin
         ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
         if (AVS_READ & ~ack_q) begin
            AVS_READDATA <= rd_mux;
         end
      end
   end

   // Read decode, unmapped reads as zero
   always @* begin
      case (AVS_ADDRESS)
         `CGC_OFS_CTRL: rd_mux = ctrl_q;
         `CGC_OFS_MODE: rd_mux = mode_q;
         `CGC_OFS_LOAD: rd_mux = load_q;
         `CGC_OFS_END: rd_mux = end_q;
         `CGC_OFS_CMP: rd_mux = cmp_q;
         `CGC_OFS_HYST: rd_mux = {{(32-HYST_W){1'b0}}, hyst_width_q};
         `CGC_OFS_COUNT: rd_mux = cnt_q;
         `CGC_OFS_STATUS: begin
            rd_mux = `CGC_RST_WORD;
            rd_mux[`CGC_STS_GATE] = gate_q;
            rd_mux[`CGC_COMPARE_LATCHED_FLAG_LIVE] = live_q;
            rd_mux[`CGC_COMPARE_LATCHED_FLAG_LATCH] = latched_q;
            rd_mux[`CGC_STS_HYST] = hyst_q;
            rd_mux[`CGC_COMPARE_LATCHED_FLAG_EN] = cmp_en;
            rd_mux[`CGC_STS_AUTO_CLOSED] = auto_closed_q;
         end
         default: rd_mux = `CGC_RST_WORD;
      endcase
   end

   // Parameter and control registers
   always @(posedge CLK) begin
      if (!RST_B) begin
         ctrl_q <= `CGC_RST_WORD;
         mode_q <= `CGC_RST_WORD;
         load_q <= `CGC_RST_WORD;
         end_q <= `CGC_RST_WORD;
         cmp_q <= `CGC_RST_WORD;
         hyst_width_q <= {HYST_W{1'b0}};
      end else if (wr_take) begin
         case (AVS_ADDRESS)
            `CGC_OFS_CTRL: ctrl_q <= ctrl_new;
            `CGC_OFS_MODE: mode_q <= be_merge(mode_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            `CGC_OFS_LOAD: load_q <= be_merge(load_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            `CGC_OFS_END: end_q <= be_merge(end_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            `CGC_OFS_CMP: cmp_q <= be_merge(cmp_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            `CGC_OFS_HYST: begin
               if (AVS_BYTEENABLE[0]) begin
                  hyst_width_q <= AVS_WRITEDATA[HYST_W-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control word edges
   assign ctrl_new = be_merge(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE);
   assign open_edge = wr_take && (AVS_ADDRESS == `CGC_OFS_CTRL)
      && ctrl_new[`CGC_CTRL_GATE_OPEN] && !ctrl_q[`CGC_CTRL_GATE_OPEN];
   assign close_edge = wr_take && (AVS_ADDRESS == `CGC_OFS_CTRL)
      && ctrl_new[`CGC_CTRL_GATE_CLOSE] && !ctrl_q[`CGC_CTRL_GATE_CLOSE];
   assign sts_reset = wr_take && (AVS_ADDRESS == `CGC_OFS_CTRL)
      && ctrl_new[`CGC_CTRL_STS_RESET];
   assign cmp_en = ctrl_q[`CGC_CTRL_CMP_EN];

   // Mode decode
   assign func = mode_q[`CGC_MODE_FUNC_MSB:`CGC_MODE_FUNC_LSB];
   assign cond = mode_q[`CGC_MODE_COND_MSB:`CGC_MODE_COND_LSB];
   assign gate_irq = mode_q[`CGC_MODE_GATE_IRQ];
   assign once_mode = (func == `CGC_FUNC_ONCE_FWD) || (func == `CGC_FUNC_ONCE_BWD);
   assign main_fwd = (func == `CGC_FUNC_ONCE_FWD) || (func == `CGC_FUNC_PER_FWD);
   assign main_bwd = (func == `CGC_FUNC_ONCE_BWD) || (func == `CGC_FUNC_PER_BWD);
   assign no_dir_once = (func == `CGC_FUNC_ONCE_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Counting
   assign step_up = gate_q & UP_PULSE & ~DOWN_PULSE;
   assign step_dn = gate_q & DOWN_PULSE & ~UP_PULSE;
   assign at_end_fwd = ($signed(cnt_q) == $signed(end_q) - 32'sd1);
   assign at_end_bwd = ($signed(cnt_q) == $signed(end_q) + 32'sd1);
   assign at_max = (cnt_q == 32'h7FFF_FFFF);
   assign at_min = (cnt_q == 32'h8000_0000);

   // Next count, gate and direction
   always @* begin
      cnt_d = cnt_q;
      gate_d = gate_q;
      auto_closed_d = auto_closed_q;
      last_dir_d = last_dir_q;
      if (close_edge) begin
         gate_d = 1'b0;
      end else if (open_edge) begin
         gate_d = 1'b1;
         auto_closed_d = 1'b0;
         // Abort, first start, or restart after auto close (not once without direction) take load
         if (!gate_irq || !started_q || (auto_closed_q && !no_dir_once)) begin
            cnt_d = load_q;
            last_dir_d = 2'b00;
         end // otherwise hold the count
      end else if (step_up) begin
         if (main_fwd && at_end_fwd) begin
            cnt_d = load_q;
            last_dir_d = 2'b00;
            if (once_mode) begin
               gate_d = 1'b0;
               auto_closed_d = 1'b1;
            end
         end else begin
            // Plain increment; wraps at the top limit
            cnt_d = cnt_q + 32'h0000_0001;
            last_dir_d = 2'b01;
            if (no_dir_once && at_max) begin
               gate_d = 1'b0;
               auto_closed_d = 1'b1;
            end
         end
      end else if (step_dn) begin
         if (main_bwd && at_end_bwd) begin
            cnt_d = load_q;
            last_dir_d = 2'b00;
            if (once_mode) begin
               gate_d = 1'b0;
               auto_closed_d = 1'b1;
            end
         end else begin
            // Plain decrement; wraps at the bottom limit
            cnt_d = cnt_q - 32'h0000_0001;
            last_dir_d = 2'b10;
            if (no_dir_once && at_min) begin
               gate_d = 1'b0;
               auto_closed_d = 1'b1;
            end
         end
      end
   end

   // Count state registers
   always @(posedge CLK) begin
      if (!RST_B) begin
         cnt_q <= `CGC_RST_WORD;
         gate_q <= 1'b0;
         auto_closed_q <= 1'b0;
         started_q <= 1'b0;
         last_dir_q <= 2'b00;
      end else begin
         cnt_q <= cnt_d;
         gate_q <= gate_d;
         auto_closed_q <= auto_closed_d;
         last_dir_q <= last_dir_d;
         if (open_edge) begin
            started_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comparison on the updated count
   assign ge_raw = ($signed(cnt_q) >= $signed(cmp_q));
   assign le_raw = ($signed(cnt_q) <= $signed(cmp_q));
   assign eq_raw = (cnt_q == cmp_q);
   // Equality only counts when reached from the main direction, if one is configured
   assign eq_hit = eq_raw && ((!main_fwd && !main_bwd)
      || (main_fwd && last_dir_q == 2'b01)
      || (main_bwd && last_dir_q == 2'b10));
   // Window around the count at arming, frozen width
   assign hyst_diff = $signed({cnt_q[31], cnt_q}) - $signed({hyst_center_q[31], hyst_center_q});
   assign hyst_span = $signed({{(33-HYST_W){1'b0}}, hyst_win_q});
   assign out_of_window = (hyst_diff > hyst_span) || (hyst_diff < -hyst_span);

   // Live compare bit and hysteresis next state
   always @* begin
      live_d = live_q;
      hyst_d = hyst_q;
      if (cmp_en && cond != `CGC_COND_NEVER) begin
         if (!hyst_q) begin
            case (cond)
               `CGC_COND_GE: live_d = ge_raw;
               `CGC_COND_LE: live_d = le_raw;
               `CGC_COND_EQ: live_d = live_q ? eq_raw : eq_hit;
               default: live_d = live_q;
            endcase
            // Arm on reaching the condition when width above one
            if (live_d && !live_q && hyst_width_q > 8'h01) begin
               hyst_d = 1'b1;
            end
         end else if (out_of_window) begin
            // Leaving the window releases the frozen result
            hyst_d = 1'b0;
            case (cond)
               `CGC_COND_GE: live_d = ge_raw;
               `CGC_COND_LE: live_d = le_raw;
               `CGC_COND_EQ: live_d = 1'b0;
               default: live_d = live_q;
            endcase
         end else begin
            // Inside window: GE and LE clear on crossing, EQ holds; never set again
            case (cond)
               `CGC_COND_GE: live_d = live_q & ge_raw;
               `CGC_COND_LE: live_d = live_q & le_raw;
               `CGC_COND_EQ: live_d = live_q;
               default: live_d = live_q;
            endcase
         end
      end
   end

   // Compare state registers
   always @(posedge CLK) begin
      if (!RST_B) begin
         live_q <= 1'b0;
         latched_q <= 1'b0;
         hyst_q <= 1'b0;
         hyst_center_q <= `CGC_RST_WORD;
         hyst_win_q <= {HYST_W{1'b0}};
      end else begin
         live_q <= live_d;
         hyst_q <= hyst_d;
         // Width sampled only at arming
         if (hyst_d && !hyst_q) begin
            hyst_center_q <= cnt_q;
            hyst_win_q <= hyst_width_q;
         end
         // Set wins over the host's clear
         if (live_d && !live_q) begin
            latched_q <= 1'b1;
         end else if (sts_reset) begin
            latched_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign COUNT_VALUE = cnt_q;
   assign GATE_OPEN = gate_q;
   assign COMPARE_LIVE = live_q;
   assign COMPARE_LATCHED = latched_q;

endmodule

`default_nettype wire

// [tb/cgc_core_properties.sv]
// Checker for the counter channel; sees only the core's ports.
// Assumes full byte lanes on writes, so the snooped copies match.
`timescale 1ns/1ps
`default_nettype none
`include "cgc_counter_regs.vh"
module cgc_core_props #(
   parameter HYST_W = 8
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [`CGC_ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic UP_PULSE,
   input wire logic DOWN_PULSE,
   input wire logic [31:0] COUNT_VALUE,
   input wire logic GATE_OPEN,
   input wire logic COMPARE_LIVE,
   input wire logic COMPARE_LATCHED
);
   logic [5:0] fn_q;
   logic [2:0] cond_q;
   logic en_q;
   logic [31:0] load_q;
   logic [31:0] end_q;
   logic [31:0] cmp_q;
   logic [7:0] hyst_q;
   logic wide_q;
   wire up_only = GATE_OPEN && UP_PULSE && !DOWN_PULSE && !AVS_WRITE;
   wire dn_only = GATE_OPEN && DOWN_PULSE && !UP_PULSE && !AVS_WRITE;
   wire ge_on = en_q && cond_q == `CGC_COND_GE && hyst_q < 8'h02 && !AVS_WRITE && !wide_q;
   // Sticky once a window may have armed; frozen results break the level check
   always_ff @(posedge CLK) wide_q <= RST_B && (wide_q || hyst_q > 8'h01);
   // Copies of accepted register writes
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         fn_q <= 6'h00;
         cond_q <= 3'h0;
         en_q <= 1'h0;
         load_q <= 32'h0000_0000;
         end_q <= 32'h0000_0000;
         cmp_q <= 32'h0000_0000;
         hyst_q <= 8'h00;
      end else if (AVS_WRITE && !AVS_WAITREQUEST) begin
         case (AVS_ADDRESS)
            `CGC_OFS_CTRL: en_q <= AVS_WRITEDATA[`CGC_CTRL_CMP_EN];
            `CGC_OFS_MODE: begin
               fn_q <= AVS_WRITEDATA[5:0];
               cond_q <= AVS_WRITEDATA[10:8];
            end
            `CGC_OFS_LOAD: load_q <= AVS_WRITEDATA;
            `CGC_OFS_END: end_q <= AVS_WRITEDATA;
            `CGC_OFS_CMP: cmp_q <= AVS_WRITEDATA;
            `CGC_OFS_HYST: hyst_q <= AVS_WRITEDATA[7:0];
            default: ;
         endcase
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_fwd_last;
      up_only && COUNT_VALUE == end_q - 32'h0000_0001;
   endsequence
   sequence s_bwd_last;
      dn_only && COUNT_VALUE == end_q + 32'h0000_0001;
   endsequence
   sequence s_ge_quiet;
      (ge_on && $changed(COUNT_VALUE)) ##1 (ge_on && $stable(COUNT_VALUE));
   endsequence
   AST_GATE_HOLD: assert property (!GATE_OPEN && !AVS_WRITE |=>
      $stable(COUNT_VALUE) && !GATE_OPEN) else $error("closed gate moved");
   AST_UP_STEP: assert property (up_only |=>
      COUNT_VALUE == $past(COUNT_VALUE) + 32'h0000_0001 || COUNT_VALUE == load_q)
      else $error("bad up step");
   AST_DN_STEP: assert property (dn_only |=>
      COUNT_VALUE == $past(COUNT_VALUE) - 32'h0000_0001 || COUNT_VALUE == load_q)
      else $error("bad down step");
   AST_ONCE_FWD_END: assert property (s_fwd_last ##0 fn_q == `CGC_FUNC_ONCE_FWD |=>
      COUNT_VALUE == load_q && !GATE_OPEN) else $error("once fwd end");
   AST_ONCE_BWD_END: assert property (s_bwd_last ##0 fn_q == `CGC_FUNC_ONCE_BWD |=>
      COUNT_VALUE == load_q && !GATE_OPEN) else $error("once bwd end");
   AST_PER_END: assert property ((s_fwd_last ##0 fn_q == `CGC_FUNC_PER_FWD) or
      (s_bwd_last ##0 fn_q == `CGC_FUNC_PER_BWD) |=> COUNT_VALUE == load_q && GATE_OPEN)
      else $error("periodic end");
   AST_LIVE_HELD: assert property (!en_q || cond_q == `CGC_COND_NEVER |=>
      $stable(COMPARE_LIVE)) else $error("live moved while held");
   AST_LATCH_WITH_LIVE: assert property ($rose(COMPARE_LIVE) |->
      COMPARE_LATCHED) else $error("latch missed");
   AST_LATCH_CLEAR: assert property (AVS_WRITE && !AVS_WAITREQUEST &&
      AVS_ADDRESS == `CGC_OFS_CTRL && AVS_WRITEDATA[`CGC_CTRL_STS_RESET] |=>
      !COMPARE_LATCHED || $rose(COMPARE_LIVE)) else $error("latch not cleared");
   AST_GE_LEVEL: assert property (s_ge_quiet |->
      COMPARE_LIVE == ($signed(COUNT_VALUE) >= $signed(cmp_q))) else $error("ge level");
endmodule
bind cgc_counter_core cgc_core_props #(.HYST_W(HYST_W)) cgc_core_props_i (
   .CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .UP_PULSE(UP_PULSE),
   .DOWN_PULSE(DOWN_PULSE), .COUNT_VALUE(COUNT_VALUE), .GATE_OPEN(GATE_OPEN),
   .COMPARE_LIVE(COMPARE_LIVE), .COMPARE_LATCHED(COMPARE_LATCHED));
`default_nettype wire

// [tb/cgc_pulse_src.sv]
// Count strobe source in place of the decoded encoder tracks.
// Assumes burst is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cgc_pulse_src (
   input wire logic CLK,
   output logic UP_PULSE,
   output logic DOWN_PULSE
);
   initial begin
      UP_PULSE = 1'h0;
      DOWN_PULSE = 1'h0;
   end
   // Run of n back-to-back one-cycle strobes
   task automatic burst(input logic up, input logic dn, input int n);
      begin
         @(posedge CLK);
         UP_PULSE <= up;
         DOWN_PULSE <= dn;
         repeat (n) @(posedge CLK);
         UP_PULSE <= 1'h0;
         DOWN_PULSE <= 1'h0;
      end
   endtask
endmodule
`default_nettype wire

// [tb/test_counter_gate_compare_core.sv]
// Self-checking bench for the counter channel.
// Assumes the regs header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "cgc_counter_regs.vh"
module test_counter_gate_compare_core;
   logic clk;
   logic rst_b;
   logic [4:0] adr;
   logic rd_en;
   logic wr_en;
   logic [31:0] wdat;
   wire [31:0] rdat;
   wire wait_rq;
   wire up;
   wire dn;
   wire [31:0] cnt;
   wire gate;
   wire live;
   wire latch;
   int err_total;
   int checked;
   logic [31:0] rd;
   cgc_counter_core #(.HYST_W(8)) cgc_counter_core_i (.CLK(clk), .RST_B(rst_b),
      .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat),
      .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq),
      .UP_PULSE(up), .DOWN_PULSE(dn), .COUNT_VALUE(cnt), .GATE_OPEN(gate),
      .COMPARE_LIVE(live), .COMPARE_LATCHED(latch));
   cgc_pulse_src cgc_pulse_src_i (.CLK(clk), .UP_PULSE(up), .DOWN_PULSE(dn));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("mismatches %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr_en <= w;
      rd_en <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wait_rq !== 1'h0 && n < 64);
      rd = rdat;
      wr_en <= 1'h0;
      rd_en <= 1'h0;
      if (n >= 64) begin
         err_total++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0000_0000);
      chk(rd, e);
   endtask
   task automatic pu(input logic u, input logic d, input int n);
      cgc_pulse_src_i.burst(u, d, n);
   endtask
   task automatic lk(input logic [31:0] c, input logic g);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(cnt, c);
      chk({31'h0000_0000, gate}, {31'h0000_0000, g});
   endtask
   task automatic fl(input logic lv, input logic lt);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({30'h0000_0000, live, latch}, {30'h0000_0000, lv, lt});
   endtask
   function automatic logic [31:0] md(input logic [5:0] f, input logic [2:0] c, input logic g);
      md = {15'h0000, g, 5'h00, c, 2'h0, f};
   endfunction
   // Close, program, then open with a fresh edge
   task automatic st(input logic [31:0] m, input logic [31:0] l, input logic [31:0] e,
         input logic [31:0] c);
      wr(`CGC_OFS_CTRL, 32'h0000_0002);
      wr(`CGC_OFS_CTRL, 32'h0000_0000);
      wr(`CGC_OFS_MODE, m);
      wr(`CGC_OFS_LOAD, l);
      wr(`CGC_OFS_END, e);
      wr(`CGC_OFS_CTRL, c);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 8; i++) rdc(5'(i * 4), 32'h0000_0000);
      rdc(5'h02, 32'h0000_0000);
      wr(`CGC_OFS_COUNT, 32'hFFFF_FFFF);
      rdc(`CGC_OFS_COUNT, 32'h0000_0000);
   endtask
   task automatic t_once();
      st(md(`CGC_FUNC_ONCE_FWD, 3'h0, 1'h0), 32'hFFFF_FFFE, 32'h0000_0001, 32'h0000_0001);
      pu(1'h1, 1'h0, 2);
      lk(32'h0000_0000, 1'h1);
      pu(1'h1, 1'h0, 1);
      lk(32'hFFFF_FFFE, 1'h0);
      rdc(`CGC_OFS_STATUS, 32'h0000_0020);
      wr(`CGC_OFS_CTRL, 32'h0000_0001);
      pu(1'h1, 1'h0, 2);
      lk(32'hFFFF_FFFE, 1'h0);
      wr(`CGC_OFS_CTRL, 32'h0000_0000);
      wr(`CGC_OFS_CTRL, 32'h0000_0001);
      pu(1'h1, 1'h0, 1);
      lk(32'hFFFF_FFFF, 1'h1);
      st(md(`CGC_FUNC_ONCE_BWD, 3'h0, 1'h0), 32'h0000_0002, 32'hFFFF_FFFF, 32'h0000_0001);
      pu(1'h0, 1'h1, 2);
      lk(32'h0000_0000, 1'h1);
      pu(1'h0, 1'h1, 1);
      lk(32'h0000_0002, 1'h0);
   endtask
   task automatic t_per();
      st(md(`CGC_FUNC_PER_FWD, 3'h0, 1'h0), 32'h0000_000A, 32'h0000_000C, 32'h0000_0001);
      pu(1'h1, 1'h0, 2);
      lk(32'h0000_000A, 1'h1);
      st(md(`CGC_FUNC_PER_BWD, 3'h0, 1'h0), 32'h0000_000A, 32'h0000_0008, 32'h0000_0001);
      pu(1'h0, 1'h1, 2);
      lk(32'h0000_000A, 1'h1);
      st(md(`CGC_FUNC_PER_FWD, 3'h0, 1'h0), 32'h8000_0000, 32'h0000_0000, 32'h0000_0001);
      pu(1'h0, 1'h1, 1);
      lk(32'h7FFF_FFFF, 1'h1);
      st(md(`CGC_FUNC_PER_BWD, 3'h0, 1'h0), 32'h7FFF_FFFF, 32'h0000_0000, 32'h0000_0001);
      pu(1'h1, 1'h0, 1);
      lk(32'h8000_0000, 1'h1);
      st(md(`CGC_FUNC_PER_NONE, 3'h0, 1'h0), 32'h7FFF_FFFF, 32'h0000_0000, 32'h0000_0001);
      pu(1'h1, 1'h0, 1);
      lk(32'h8000_0000, 1'h1);
      pu(1'h0, 1'h1, 2);
      pu(1'h1, 1'h1, 2);
      lk(32'h7FFF_FFFE, 1'h1);
      st(md(`CGC_FUNC_ONCE_NONE, 3'h0, 1'h0), 32'h7FFF_FFFF, 32'h0, 32'h0000_0001);
      pu(1'h1, 1'h0, 1);
      lk(32'h8000_0000, 1'h0);
   endtask
   task automatic t_gate();
      st(md(`CGC_FUNC_PER_NONE, 3'h0, 1'h0), 32'h0000_0064, 32'h0000_0000, 32'h0000_0001);
      pu(1'h1, 1'h0, 2);
      wr(`CGC_OFS_CTRL, 32'h0000_0002);
      pu(1'h1, 1'h0, 3);
      lk(32'h0000_0066, 1'h0);
      wr(`CGC_OFS_CTRL, 32'h0000_0001);
      lk(32'h0000_0064, 1'h1);
      wr(`CGC_OFS_MODE, md(`CGC_FUNC_PER_NONE, 3'h0, 1'h1));
      pu(1'h1, 1'h0, 2);
      wr(`CGC_OFS_CTRL, 32'h0000_0002);
      wr(`CGC_OFS_CTRL, 32'h0000_0001);
      lk(32'h0000_0066, 1'h1);
   endtask
   task automatic t_cmp();
      wr(`CGC_OFS_CMP, 32'h0000_0005);
      wr(`CGC_OFS_HYST, 32'h0000_0001);
      st(md(`CGC_FUNC_PER_NONE, `CGC_COND_GE, 1'h0), 32'h0000_0003, 32'h0, 32'h0000_0009);
      pu(1'h1, 1'h0, 1);
      fl(1'h0, 1'h0);
      pu(1'h1, 1'h0, 1);
      fl(1'h1, 1'h1);
      pu(1'h0, 1'h1, 1);
      fl(1'h0, 1'h1);
      wr(`CGC_OFS_CTRL, 32'h0000_000D);
      fl(1'h0, 1'h0);
      wr(`CGC_OFS_CTRL, 32'h0000_0009);
      wr(`CGC_OFS_MODE, md(`CGC_FUNC_PER_NONE, `CGC_COND_LE, 1'h0));
      pu(1'h0, 1'h1, 1);
      fl(1'h1, 1'h1);
      wr(`CGC_OFS_CTRL, 32'h0000_0001);
      pu(1'h1, 1'h0, 3);
      fl(1'h1, 1'h1);
      wr(`CGC_OFS_CTRL, 32'h0000_0009);
      pu(1'h1, 1'h0, 1);
      fl(1'h0, 1'h1);
      wr(`CGC_OFS_MODE, md(`CGC_FUNC_PER_NONE, `CGC_COND_EQ, 1'h0));
      pu(1'h0, 1'h1, 2);
      fl(1'h1, 1'h1);
      wr(`CGC_OFS_MODE, md(`CGC_FUNC_PER_NONE, `CGC_COND_NEVER, 1'h0));
      pu(1'h0, 1'h1, 1);
      fl(1'h1, 1'h1);
      st(md(`CGC_FUNC_PER_FWD, `CGC_COND_EQ, 1'h0), 32'h7, 32'h0000_0064, 32'h0000_0009);
      wr(`CGC_OFS_CTRL, 32'h0000_000D);
      pu(1'h0, 1'h1, 2);
      fl(1'h0, 1'h0);
      pu(1'h0, 1'h1, 1);
      pu(1'h1, 1'h0, 1);
      fl(1'h1, 1'h1);
   endtask
   task automatic t_hyst();
      wr(`CGC_OFS_HYST, 32'h0000_0003);
      st(md(`CGC_FUNC_PER_NONE, `CGC_COND_GE, 1'h0), 32'h4, 32'h0, 32'h0000_0009);
      wr(`CGC_OFS_CTRL, 32'h0000_000D);
      wr(`CGC_OFS_CTRL, 32'h0000_0009);
      pu(1'h1, 1'h0, 1);
      fl(1'h1, 1'h1);
      wr(`CGC_OFS_HYST, 32'h0000_0000);
      pu(1'h0, 1'h1, 1);
      fl(1'h0, 1'h1);
      pu(1'h1, 1'h0, 1);
      fl(1'h0, 1'h1);
      pu(1'h1, 1'h0, 4);
      fl(1'h1, 1'h1);
      wr(`CGC_OFS_HYST, 32'h0000_0003);
      wr(`CGC_OFS_MODE, md(`CGC_FUNC_PER_NONE, `CGC_COND_EQ, 1'h0));
      pu(1'h0, 1'h1, 4);
      pu(1'h0, 1'h1, 1);
      fl(1'h1, 1'h1);
      pu(1'h0, 1'h1, 3);
      fl(1'h0, 1'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'h0;
      adr = 5'h00;
      rd_en = 1'h0;
      wr_en = 1'h0;
      wdat = 32'h0000_0000;
      err_total = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'h1;
      t_reset();
      t_once();
      t_per();
      t_gate();
      t_cmp();
      t_hyst();
      finish_test();
   end
endmodule
`default_nettype wire
